/* File: hdl/level_sync.sv */
// two-flop synchroniser for levels arriving from outside the input clock domain
`timescale 1ns/100ps
`default_nettype none
module level_sync
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic level_in,
	output logic level_out
);
	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;

	always_comb
	begin
		meta_nxt = level_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign level_out = sync_r;
endmodule : level_sync
`default_nettype wire

/* File: hdl/parity_check.sv */
// even-parity check of the shared command word and open-drain error pulse timing
`timescale 1ns/100ps
`default_nettype none
module parity_check
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire rcd_pkg::cmd_t data_in,
	input wire logic data_valid,
	input wire logic parity_in,
	input wire logic parity_en,
	input wire logic quiet,
	output logic check_valid,
	output logic check_bad,
	output logic err_low,
	output logic err_level
);
	import rcd_pkg::*;

	cmd_t data_r, data_nxt, data2_r, data2_nxt;
	logic valid_r, valid_nxt, valid2_r, valid2_nxt;
	logic par_r, par_nxt, det_r, det_nxt;
	logic err_r, err_nxt, lvl_r, lvl_nxt;
	logic [1:0] hold_r, hold_nxt;

	// parity of word n arrives with edge n+1, so the word waits one stage for it
	assign check_valid = valid2_r;
	assign check_bad = valid2_r & (^{data2_r, par_r});

	always_comb
	begin
		data_nxt = data_in;
		valid_nxt = data_valid;
		data2_nxt = data_r;
		valid2_nxt = valid_r;
		par_nxt = parity_en ? parity_in : par_r;
		det_nxt = check_bad;
		err_nxt = 1'b0;
		hold_nxt = hold_r;
		if (det_r)
		begin
			err_nxt = 1'b1;
			hold_nxt = PERR_HOLD;
		end
		else if (hold_r != 2'h0)
		begin
			err_nxt = 1'b1;
			hold_nxt = hold_r - 2'h1;
		end
		if (quiet)
		begin
			err_nxt = 1'b0;
			hold_nxt = 2'h0;
		end
		lvl_nxt = ~err_nxt;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			data_r <= '0;
			data2_r <= '0;
			valid_r <= 1'b0;
			valid2_r <= 1'b0;
			par_r <= 1'b0;
			det_r <= 1'b0;
			err_r <= 1'b0;
			lvl_r <= 1'b1;
			hold_r <= 2'h0;
		end
		else
		begin
			data_r <= data_nxt;
			data2_r <= data2_nxt;
			valid_r <= valid_nxt;
			valid2_r <= valid2_nxt;
			par_r <= par_nxt;
			det_r <= det_nxt;
			err_r <= err_nxt;
			lvl_r <= lvl_nxt;
			hold_r <= hold_nxt;
		end
	end

	assign err_low = err_r;
	assign err_level = lvl_r;

	property p_err_delay;
		@(posedge clk_sys) disable iff (!reset_n)
		(check_bad && !quiet) ##1 !quiet |-> ##1 err_r;
	endproperty
	a_err_delay: assert property (p_err_delay) else $error("error pin not low three cycles after bad word");

	property p_err_min;
		@(posedge clk_sys) disable iff (!reset_n)
		($rose(err_r) && !quiet) ##1 !quiet |-> err_r;
	endproperty
	a_err_min: assert property (p_err_min) else $error("error pin low for less than two cycles");

	property p_err_release;
		@(posedge clk_sys) disable iff (!reset_n)
		(check_bad && !quiet) ##1 (!check_bad && !quiet)[*2] |-> ##1 err_r ##1 !err_r;
	endproperty
	a_err_release: assert property (p_err_release) else $error("error pin not released on fifth cycle");

	property p_deselect;
		@(posedge clk_sys) disable iff (!reset_n)
		!data_valid |-> ##2 !check_bad;
	endproperty
	a_deselect: assert property (p_deselect) else $error("parity error flagged on unqualified word");

	property p_even;
		@(posedge clk_sys) disable iff (!reset_n)
		data_valid ##1 parity_en |=> check_bad == (^{$past(data_in, 2), $past(parity_in)});
	endproperty
	a_even: assert property (p_even) else $error("parity verdict disagrees with even parity of word and bit");
endmodule : parity_check
`default_nettype wire

/* File: hdl/rcd_pkg.sv */
// shared widths, timing counts, control-word layout and carrier types for the parity and power-down block
package rcd_pkg;

	localparam int CS_W = 4;
	localparam int CKE_W = 2;
	localparam int ODT_W = 2;
	localparam int ADDR_W = 16;
	localparam int BA_W = 3;
	localparam int CNT_W = 4;
	localparam int CW_IDX_W = 4;

	// one shared address/command word, the only inputs covered by parity
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [BA_W-1:0] ba;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} cmd_t;

	// per-module control nets, left out of parity
	typedef struct packed {
		logic [CS_W-1:0] cs_n;
		logic [CKE_W-1:0] cke;
		logic [ODT_W-1:0] odt;
	} ctl_t;

	typedef enum {ST_ACTIVE, ST_PD, ST_EXIT} pd_state_t;

	// timing in input clock cycles
	localparam logic [CNT_W-1:0] IN_DIS_CYC = 4'h2;
	localparam logic [CNT_W-1:0] OUT_DIS_CYC = 4'h3;
	localparam logic [CNT_W-1:0] FIXED_CYC = 4'h8;
	localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [1:0] PERR_HOLD = 2'h1;

	// control-word index in addr low bits, value in ba
	localparam logic [CW_IDX_W-1:0] CW_FLOAT_IDX = 4'h1;
	localparam logic [CW_IDX_W-1:0] CW_PD_IDX = 4'h9;
	localparam int FLOAT_BIT = 0;
	localparam int PD_EN_BIT = 1;
	localparam int PD_KEEP_BIT = 0;

	localparam logic [CS_W-1:0] CS_IDLE = 4'hF;
	localparam logic [CKE_W-1:0] CKE_OFF = 2'h0;
	localparam logic [ODT_W-1:0] ODT_OFF = 2'h0;

endpackage : rcd_pkg

/* File: hdl/rcd_power_ctrl.sv */
// parity reporting, chip-select float, clock-enable power-down and clock-stop control of the registering driver
// Operation
// - Error pin goes low three clocks after the failing word is registered.
// - Error pin stays low at least two clocks unless reset or clock stop intervenes.
// - Error pin released on fifth clock after the last failing word.
// - Only shared address and command inputs enter the parity sum.
// - Words with every chip select high are never reported.
// - Control-word writes are parity checked; a failing write is dropped.
// - Clock stopped: all outputs float except clock enables driven low.
// - Control words survive clock stop; only reset clears them.
// - Float option with all selects high floats the gated outputs.
// - Reset beats power saving: floats, error high, cke low, termination off.
// - Power-down entered when both clock enables latch low after a fall.
// - A command selected on the entry cycle is forwarded with cke low.
// - Keep bit chooses termination off or on during power-down.
// - Receivers off after the input delay; parity input stays one clock longer.
// - Termination off: odt and cke low, gated outputs float after delay.
// - Termination on: odt receivers stay active and odt follows input.
// - Rising cke drives cke out high, selects high, odt low if off.
// - Address/command outputs held at fixed levels for the fixed time before following inputs.
// - Selects held high at most one clock on exit, otherwise follow.
`timescale 1ns/100ps
`default_nettype none
module rcd_power_ctrl
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire rcd_pkg::cmd_t cmd_in,
	input wire rcd_pkg::ctl_t ctl_in,
	input wire logic parity_in,
	input wire logic clock_stop_in,
	output rcd_pkg::cmd_t cmd_out,
	output logic cmd_oe,
	output rcd_pkg::ctl_t ctl_out,
	output logic cs_oe,
	output logic odt_oe,
	output logic parity_error_out,
	output logic parity_error_oe,
	output logic clock_out_en,
	output logic ibt_en,
	output logic rx_en,
	output logic power_down
);
	import rcd_pkg::*;

	pd_state_t st_r, st_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	cmd_t cmd_out_r, cmd_out_nxt;
	ctl_t ctl_out_r, ctl_out_nxt;
	logic cmd_oe_r, cmd_oe_nxt, cs_oe_r, cs_oe_nxt, odt_oe_r, odt_oe_nxt;
	logic clk_en_r, clk_en_nxt, ibt_r, ibt_nxt, rx_en_r, rx_en_nxt;
	logic rx_dly_r, rx_dly_nxt, pd_r, pd_nxt;
	logic [CKE_W-1:0] cke_prev_r, cke_prev_nxt;
	logic float_en_r, float_en_nxt, pd_en_r, pd_en_nxt, keep_r, keep_nxt;
	logic pend1_r, pend1_nxt, pend2_r, pend2_nxt;
	cmd_t cw1_r, cw1_nxt, cw2_r, cw2_nxt;
	logic halt_s, cs_idle, cw_acc, pd_enter, chk_valid, chk_bad, chk_err_low, chk_err_lvl;
	logic [CW_IDX_W-1:0] cw_idx;

	level_sync u_halt_sync
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.level_in(clock_stop_in),
		.level_out(halt_s)
	);

	assign cs_idle = &ctl_in.cs_n;
	// in ST_ACTIVE with receivers on, both dual selects low is a control-word access, never a DRAM command
	assign cw_acc = (st_r == ST_ACTIVE) && rx_en_r && !halt_s && !ctl_in.cs_n[0] && !ctl_in.cs_n[1];
	assign pd_enter = (st_r == ST_ACTIVE) && pd_en_r && (ctl_in.cke == CKE_OFF) && (cke_prev_r != CKE_OFF);
	assign cw_idx = cw2_r.addr[CW_IDX_W-1:0];

	// only the shared word feeds the check; selects, cke and odt stay out
	parity_check u_parity
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.data_in(cmd_in),
		.data_valid((st_r == ST_ACTIVE) && rx_en_r && !halt_s && !cs_idle),
		.parity_in(parity_in),
		.parity_en(rx_en_r || rx_dly_r),
		.quiet(halt_s),
		.check_valid(chk_valid),
		.check_bad(chk_bad),
		.err_low(chk_err_low),
		.err_level(chk_err_lvl)
	);

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + CNT_ONE;
		cmd_out_nxt = cmd_out_r;
		ctl_out_nxt = ctl_out_r;
		cmd_oe_nxt = cmd_oe_r;
		cs_oe_nxt = cs_oe_r;
		odt_oe_nxt = odt_oe_r;
		clk_en_nxt = 1'b1;
		ibt_nxt = ibt_r;
		rx_en_nxt = rx_en_r;
		rx_dly_nxt = rx_en_r;
		pd_nxt = 1'b0;
		cke_prev_nxt = ctl_in.cke;
		unique case (st_r)
			ST_ACTIVE:
			begin
				rx_en_nxt = 1'b1;
				ibt_nxt = 1'b1;
				cs_oe_nxt = 1'b1;
				odt_oe_nxt = 1'b1;
				ctl_out_nxt.cke = ctl_in.cke;
				ctl_out_nxt.odt = ctl_in.odt;
				if (cw_acc)
				begin
					// control-word access keeps the DRAM side quiet
					ctl_out_nxt.cs_n = CS_IDLE;
				end
				else
				begin
					ctl_out_nxt.cs_n = ctl_in.cs_n;
					cmd_out_nxt = cmd_in;
				end
				cmd_oe_nxt = !(float_en_r && cs_idle);
				if (pd_enter)
				begin
					st_nxt = ST_PD;
					cnt_nxt = CNT_ZERO;
					pd_nxt = 1'b1;
				end
			end
			ST_PD:
			begin
				pd_nxt = 1'b1;
				ctl_out_nxt.cke = CKE_OFF;
				ibt_nxt = keep_r;
				rx_en_nxt = (cnt_r < IN_DIS_CYC);
				ctl_out_nxt.odt = keep_r ? ctl_in.odt : ODT_OFF;
				odt_oe_nxt = 1'b1;
				if (cnt_r >= OUT_DIS_CYC)
				begin
					cmd_oe_nxt = 1'b0;
					cs_oe_nxt = 1'b0;
				end
				if (ctl_in.cke != CKE_OFF)
				begin
					st_nxt = ST_EXIT;
					cnt_nxt = CNT_ZERO;
					ctl_out_nxt.cke = ctl_in.cke;
					ctl_out_nxt.cs_n = CS_IDLE;
					ctl_out_nxt.odt = keep_r ? ctl_in.odt : ODT_OFF;
					cmd_oe_nxt = 1'b1;
					cs_oe_nxt = 1'b1;
					rx_en_nxt = 1'b1;
					ibt_nxt = 1'b1;
					pd_nxt = 1'b0;
				end
			end
			ST_EXIT:
			begin
				// address/command stays frozen while receivers settle
				ctl_out_nxt.cke = ctl_in.cke;
				ctl_out_nxt.cs_n = ctl_in.cs_n;
				ctl_out_nxt.odt = keep_r ? ctl_in.odt : ODT_OFF;
				rx_en_nxt = 1'b1;
				ibt_nxt = 1'b1;
				cmd_oe_nxt = 1'b1;
				cs_oe_nxt = 1'b1;
				if (cnt_r >= FIXED_CYC)
				begin
					st_nxt = ST_ACTIVE;
				end
			end
		endcase
		if (halt_s)
		begin
			// clock stopped: only cke stays driven, and it is low
			st_nxt = ST_ACTIVE;
			ctl_out_nxt.cke = CKE_OFF;
			cmd_oe_nxt = 1'b0;
			cs_oe_nxt = 1'b0;
			odt_oe_nxt = 1'b0;
			clk_en_nxt = 1'b0;
			rx_en_nxt = 1'b0;
			ibt_nxt = 1'b0;
			pd_nxt = 1'b0;
		end
	end

	// control words: a write lands two edges later, once its parity has been judged
	always_comb
	begin
		pend1_nxt = cw_acc;
		cw1_nxt = cmd_in;
		pend2_nxt = pend1_r;
		cw2_nxt = cw1_r;
		float_en_nxt = float_en_r;
		pd_en_nxt = pd_en_r;
		keep_nxt = keep_r;
		if (pend2_r && chk_valid && !chk_bad)
		begin
			if (cw_idx == CW_FLOAT_IDX)
			begin
				float_en_nxt = cw2_r.ba[FLOAT_BIT];
			end
			if (cw_idx == CW_PD_IDX)
			begin
				pd_en_nxt = cw2_r.ba[PD_EN_BIT];
				keep_nxt = cw2_r.ba[PD_KEEP_BIT];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r <= ST_ACTIVE;
			cnt_r <= CNT_ZERO;
			cmd_out_r <= '0;
			ctl_out_r <= {CS_IDLE, CKE_OFF, ODT_OFF};
			cmd_oe_r <= 1'b0;
			cs_oe_r <= 1'b0;
			odt_oe_r <= 1'b0;
			clk_en_r <= 1'b0;
			ibt_r <= 1'b0;
			rx_en_r <= 1'b0;
			rx_dly_r <= 1'b0;
			pd_r <= 1'b0;
			cke_prev_r <= CKE_OFF;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			cmd_out_r <= cmd_out_nxt;
			ctl_out_r <= ctl_out_nxt;
			cmd_oe_r <= cmd_oe_nxt;
			cs_oe_r <= cs_oe_nxt;
			odt_oe_r <= odt_oe_nxt;
			clk_en_r <= clk_en_nxt;
			ibt_r <= ibt_nxt;
			rx_en_r <= rx_en_nxt;
			rx_dly_r <= rx_dly_nxt;
			pd_r <= pd_nxt;
			cke_prev_r <= cke_prev_nxt;
		end
	end

	// clock stop leaves these alone, only reset clears them
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pend1_r <= 1'b0;
			pend2_r <= 1'b0;
			cw1_r <= '0;
			cw2_r <= '0;
			float_en_r <= 1'b0;
			pd_en_r <= 1'b0;
			keep_r <= 1'b0;
		end
		else
		begin
			pend1_r <= pend1_nxt;
			pend2_r <= pend2_nxt;
			cw1_r <= cw1_nxt;
			cw2_r <= cw2_nxt;
			float_en_r <= float_en_nxt;
			pd_en_r <= pd_en_nxt;
			keep_r <= keep_nxt;
		end
	end

	assign cmd_out = cmd_out_r;
	assign cmd_oe = cmd_oe_r;
	assign ctl_out = ctl_out_r;
	assign cs_oe = cs_oe_r;
	assign odt_oe = odt_oe_r;
	assign parity_error_out = chk_err_lvl;
	assign parity_error_oe = chk_err_low;
	assign clock_out_en = clk_en_r;
	assign ibt_en = ibt_r;
	assign rx_en = rx_en_r;
	assign power_down = pd_r;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	property p_clock_stop;
		halt_s |=> (ctl_out_r.cke == CKE_OFF) && !cmd_oe_r && !cs_oe_r && !odt_oe_r && !clk_en_r && !chk_err_low;
	endproperty
	a_clock_stop: assert property (p_clock_stop) else $error("outputs not floated in clock stop");

	property p_cw_retain;
		halt_s && !pend2_r |=> $stable(float_en_r) && $stable(pd_en_r) && $stable(keep_r);
	endproperty
	a_cw_retain: assert property (p_cw_retain) else $error("control word lost during clock stop");

	property p_cw_drop;
		pend2_r && chk_bad |=> $stable(float_en_r) && $stable(pd_en_r) && $stable(keep_r);
	endproperty
	a_cw_drop: assert property (p_cw_drop) else $error("control write with parity error took effect");

	property p_float;
		(st_r == ST_ACTIVE) && !halt_s && float_en_r && cs_idle && !pd_enter |=> !cmd_oe_r;
	endproperty
	a_float: assert property (p_float) else $error("gated outputs driven with all selects high");

	property p_pd_entry;
		pd_enter && !halt_s |=> (st_r == ST_PD) && (ctl_out_r.cke == CKE_OFF) && pd_r;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered after cke fall");

	property p_pd_off_outputs;
		(st_r == ST_PD) && !keep_r && !halt_s && (ctl_in.cke == CKE_OFF) |=>
			(ctl_out_r.odt == ODT_OFF) && odt_oe_r && !ibt_r && (cnt_r <= OUT_DIS_CYC || !cmd_oe_r);
	endproperty
	a_pd_off_outputs: assert property (p_pd_off_outputs) else $error("termination-off power-down outputs wrong");

	property p_pd_keep_odt;
		(st_r == ST_PD) && keep_r && !halt_s |=> (ctl_out_r.odt == $past(ctl_in.odt)) && ibt_r;
	endproperty
	a_pd_keep_odt: assert property (p_pd_keep_odt) else $error("odt not following input with termination kept");

	property p_exit_wake;
		(st_r == ST_PD) && (ctl_in.cke != CKE_OFF) && !halt_s |=>
			(ctl_out_r.cke == $past(ctl_in.cke)) && (ctl_out_r.cs_n == CS_IDLE) && (st_r == ST_EXIT);
	endproperty
	a_exit_wake: assert property (p_exit_wake) else $error("wake did not raise cke and selects");

	property p_exit_fixed;
		(st_r == ST_EXIT) && !halt_s |=> $stable(cmd_out_r);
	endproperty
	a_exit_fixed: assert property (p_exit_fixed) else $error("command outputs moved during fixed-output time");

	property p_exit_cs;
		(st_r == ST_EXIT) && !halt_s |=> ctl_out_r.cs_n == $past(ctl_in.cs_n);
	endproperty
	a_exit_cs: assert property (p_exit_cs) else $error("selects held high longer than one clock");
endmodule : rcd_power_ctrl
`default_nettype wire

/* File: tb/host_model.sv */
// controller-side model that sends even parity for each word one clock late
`timescale 1ns/100ps
`default_nettype none
module host_model
(
	input wire logic clk_sys,
	input wire rcd_pkg::cmd_t cmd_in,
	input wire logic corrupt,
	output logic parity_in
);
	import rcd_pkg::*;
	cmd_t last_r;
	logic bad_r;
	initial parity_in = 1'b0;
	always_ff @(posedge clk_sys)
	begin
		last_r <= cmd_in;
		bad_r <= corrupt;
	end
	// launched on the falling edge so the block takes it at the next rising edge
	always @(negedge clk_sys)
		parity_in <= (^last_r) ^ bad_r;
endmodule : host_model
`default_nettype wire

/* File: tb/rcd_parity_and_power_down_tb.sv */
// self-checking bench for parity reporting, float, power-down and clock stop
`timescale 1ns/100ps
`default_nettype none
module rcd_parity_and_power_down_tb;
	import rcd_pkg::*;
	logic clk_sys, reset_n, parity_in, clock_stop_in, corrupt;
	cmd_t cmd_in, cmd_out;
	ctl_t ctl_in, ctl_out;
	logic cmd_oe, cs_oe, odt_oe, parity_error_out, parity_error_oe, clock_out_en, ibt_en, rx_en, power_down;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	logic [4:0] hist;
	logic [3:0] cs_tab [5] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF};
	// consecutive errors, then gaps of one and of three clean words
	localparam logic [7:0] PAT = 8'h8B;

	rcd_power_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .cmd_in(cmd_in), .ctl_in(ctl_in),
		.parity_in(parity_in), .clock_stop_in(clock_stop_in), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
		.ctl_out(ctl_out), .cs_oe(cs_oe), .odt_oe(odt_oe), .parity_error_out(parity_error_out),
		.parity_error_oe(parity_error_oe), .clock_out_en(clock_out_en), .ibt_en(ibt_en),
		.rx_en(rx_en), .power_down(power_down));
	host_model host (.clk_sys(clk_sys), .cmd_in(cmd_in), .corrupt(corrupt), .parity_in(parity_in));

	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	task automatic done(input string s);
		$display("test %s over", s);
	endtask : done

	function automatic cmd_t rnd();
		return cmd_t'(22'($urandom));
	endfunction : rnd

	function automatic cmd_t cw(input logic [3:0] idx, input logic [2:0] v);
		cmd_t c;
		c = rnd();
		c.addr[3:0] = idx;
		c.ba = v;
		return c;
	endfunction : cw

	// called at a falling edge; returns one clock later with that edge's results settled
	task automatic put(input cmd_t c, input logic [3:0] cs, input logic [1:0] ck, input logic [1:0] od,
		input logic bad);
		cmd_in = c;
		ctl_in = {cs, ck, od};
		corrupt = bad;
		@(negedge clk_sys);
	endtask : put

	task automatic idle(input logic [1:0] ck, input logic [1:0] od);
		put(rnd(), CS_IDLE, ck, od, 1'b0);
	endtask : idle

	task automatic rst_chk;
		chk("cmd_oe", 0, cmd_oe);
		chk("cs_oe", 0, cs_oe);
		chk("err_pin", 1, parity_error_out);
		chk("cke_out", 0, ctl_out.cke);
		chk("ibt_en", 0, ibt_en);
		chk("power_down", 0, power_down);
	endtask : rst_chk

	task automatic pd(input logic keep);
		cmd_t w, w2;
		w = rnd();
		w2 = rnd();
		put(cw(CW_PD_IDX, {1'b0, 1'b1, keep}), 4'hC, 2'h3, 2'h0, 1'b0);
		chk("cs_out", CS_IDLE, ctl_out.cs_n);
		idle(2'h3, 2'h0);
		idle(2'h3, 2'h0);
		put(w, 4'hE, CKE_OFF, 2'h3, 1'b0);
		chk("power_down", 1, power_down);
		chk("cke_out", 0, ctl_out.cke);
		chk("cmd_out", w, cmd_out);
		chk("cs_out", 4'hE, ctl_out.cs_n);
		idle(CKE_OFF, 2'h3);
		chk("ibt_en", keep, ibt_en);
		idle(CKE_OFF, 2'h3);
		idle(CKE_OFF, 2'h3);
		chk("rx_en", 0, rx_en);
		idle(CKE_OFF, 2'h3);
		chk("cmd_oe", 0, cmd_oe);
		chk("cs_oe", 0, cs_oe);
		chk("odt_out", keep ? 3 : 0, ctl_out.odt);
		put(w2, CS_IDLE, 2'h1, 2'h3, 1'b0);
		chk("cke_out", 1, ctl_out.cke);
		chk("cs_out", CS_IDLE, ctl_out.cs_n);
		chk("odt_out", keep ? 3 : 0, ctl_out.odt);
		put(w2, 4'hE, 2'h3, 2'h3, 1'b0);
		chk("cs_out", 4'hE, ctl_out.cs_n);
		repeat (8) put(w2, CS_IDLE, 2'h3, 2'h0, 1'b0);
		chk("cmd_out", w, cmd_out);
		// the first edge back in normal operation already forwards the new word
		put(w2, CS_IDLE, 2'h3, 2'h0, 1'b0);
		chk("cmd_out", w2, cmd_out);
		done("power-down");
	endtask : pd

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fail_count++;
			give_verdict();
		end
	end

	initial
	begin
		reset_n = 1'b0;
		clock_stop_in = 1'b0;
		cmd_in = '0;
		ctl_in = {CS_IDLE, CKE_OFF, ODT_OFF};
		corrupt = 1'b0;
		hist = '0;
		void'($urandom(11394));
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_chk();
		reset_n = 1'b1;
		idle(CKE_OFF, 2'h0);
		for (int i = 0; i < 80; i++)
		begin
			cmd_t w;
			logic [3:0] cs;
			logic b;
			w = rnd();
			cs = (i < 8) ? 4'hE : cs_tab[$urandom % 5];
			b = (i < 8) ? PAT[i] : ($urandom % 4 == 0);
			put(w, cs, 2'($urandom), 2'($urandom), b);
			hist = {hist[3:0], b & (cs != CS_IDLE)};
			chk("cmd_out", w, cmd_out);
			chk("cs_out", cs, ctl_out.cs_n);
			chk("err_oe", hist[3] | hist[4], parity_error_oe);
			chk("err_pin", !(hist[3] | hist[4]), parity_error_out);
		end
		done("parity");
		put(cw(CW_PD_IDX, 3'h3), 4'hC, 2'h3, 2'h0, 1'b1);
		idle(2'h3, 2'h0);
		idle(2'h3, 2'h0);
		put(rnd(), 4'hE, CKE_OFF, 2'h0, 1'b0);
		chk("power_down", 0, power_down);
		chk("err_oe", 1, parity_error_oe);
		repeat (3) idle(2'h3, 2'h0);
		done("bad control word");
		pd(1'b0);
		pd(1'b1);
		put(cw(CW_FLOAT_IDX, 3'h1), 4'hC, 2'h3, 2'h0, 1'b0);
		repeat (3) idle(2'h3, 2'h0);
		chk("cmd_oe", 0, cmd_oe);
		put(rnd(), 4'hD, 2'h3, 2'h0, 1'b0);
		chk("cmd_oe", 1, cmd_oe);
		done("float");
		// memories are taken to be in self-refresh here, no DRAM traffic follows
		clock_stop_in = 1'b1;
		repeat (4) idle(CKE_OFF, 2'h0);
		chk("cke_out", 0, ctl_out.cke);
		chk("cmd_oe", 0, cmd_oe);
		chk("cs_oe", 0, cs_oe);
		chk("odt_oe", 0, odt_oe);
		chk("clock_out_en", 0, clock_out_en);
		clock_stop_in = 1'b0;
		repeat (4) idle(CKE_OFF, 2'h0);
		idle(2'h3, 2'h0);
		put(rnd(), 4'hE, CKE_OFF, 2'h0, 1'b0);
		chk("power_down", 1, power_down);
		done("clock stop");
		// mid-run reset while powered down must win at once, without a clock edge
		reset_n = 1'b0;
		#5;
		rst_chk();
		repeat (2) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (2) idle(2'h3, 2'h0);
		put(rnd(), 4'hE, CKE_OFF, 2'h0, 1'b0);
		chk("power_down", 0, power_down);
		done("reset");
		give_verdict();
	end
endmodule : rcd_parity_and_power_down_tb
`default_nettype wire
